// ==== hw/liu_cfg_map.svh ====
// Purpose: Register offsets, field positions and reset values for the LIU configuration/alarm bank
// Assumes: 8-bit host register port, byte offsets
// Notes: Definitions only
`ifndef LIU_CFG_MAP_SVH
`define LIU_CFG_MAP_SVH
`define LIU_OFS_LOS_STATUS 8'h04
`define LIU_OFS_AUTO_ALL_ONES 8'h0e
`define LIU_OFS_GLOBAL_CONFIG 8'h0f
`define LIU_OFS_TPL_POINTER 8'h10
`define LIU_OFS_TPL_CODE 8'h11
`define LIU_OFS_DRV_HIGHZ 8'h12
`define LIU_OFS_AIS_STATUS 8'h13
`define LIU_OFS_AIS_MASK 8'h14
`define LIU_OFS_AIS_IRQ 8'h15
`define LIU_OFS_IRQ_STATUS 8'h16
`define LIU_OFS_IRQ_MASK 8'h17
`define LIU_CFG_INSERT_BIT 6
`define LIU_CFG_SHORT_BIT 5
`define LIU_CFG_CODE_BIT 4
`define LIU_CFG_DEPTH_BIT 3
`define LIU_CFG_BW_BIT 2
`define LIU_CFG_RESET 8'h00
`define LIU_CFG_WMASK 8'h7f
`define LIU_PTR_WMASK 8'h07
`define LIU_TPL_WMASK 8'h07
`define LIU_TPL_RESET 3'h0
`define LIU_REG_RESET 8'h00
`define LIU_JA_TX 2'b01
`define LIU_JA_RX 2'b11
`endif

// ==== hw/liu_pkg.sv ====
// Purpose: Types for the LIU configuration/alarm bank
// Assumes: Eight channels
// Notes: Constants live in liu_cfg_map.svh
package liu_pkg;
    typedef logic [7:0] liu_byte_t;
    typedef logic [2:0] liu_tpl_t;
    typedef struct packed {
        liu_byte_t auto_all_ones_enable;
        liu_byte_t global_config;
        liu_byte_t template_channel_pointer;
        liu_tpl_t [7:0] pulse_template_code;
        liu_byte_t driver_highz;
        liu_byte_t alarm_irq_mask;
        liu_byte_t alarm_irq_status;
        liu_byte_t los_s1;
        liu_byte_t los_s2;
        liu_byte_t los_s3;
        liu_byte_t los_stable;
        liu_byte_t ais_s1;
        liu_byte_t ais_s2;
        liu_byte_t ais_s3;
        liu_byte_t ais_stable;
        liu_byte_t ais_prev;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        liu_byte_t rdata;
    } liu_state_s;
endpackage

// ==== hw/liu_cfg_regs.sv ====
// Purpose: Configuration and alarm register bank of an eight-channel T1/E1 line interface
// Assumes: Host port with one-cycle strobes; LOS and ALARM_INDICATION_STATUS detector levels come from outside the clock domain
// Notes: Read data stands in the cycle after the read strobe only
`timescale 1ns/10ps
`default_nettype none
`include "liu_cfg_map.svh"

// Overview of operation
// - A channel sends all ones to the line during loss of signal when its automatic all-ones bit is set.
// - Global bit 6 makes the system side of a channel in loss of signal carry alarm indication.
// - Global bit 5 low keeps transmit short-circuit protection on, high turns it off.
// - Global bit 4 low picks B8ZS/HDB3 coding, high picks AMI.
// - Global bit 3 picks a 32-bit (low) or 64-bit (high) attenuator FIFO.
// - Global bit 2 picks the low or high jitter transfer bandwidth.
// - Placement 01 puts the attenuator in transmit, 11 in receive, 00 and 10 leave it out.
// - The three-bit pointer picks channel 0 to 7 for the template register.
// - The three-bit template code picks the transmit pulse shape, E1 or a T1 cable range.
// - A set driver bit puts that channel's transmit driver in high impedance.
// - The alarm status register shows one per channel while alarm indication is detected.
// - An alarm mask bit of one allows that channel's alarm interrupt; all reset to blocked.
// - An alarm interrupt bit sets on either edge of its alarm status while its mask bit is one.
// - Alarm interrupt bits clear on a read of the alarm status register and are zero after reset.
// - The loss-of-signal status register shows one per channel while loss is detected.
module liu_cfg_regs
    import liu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] los_in,
    input wire logic [7:0] ais_in,
    output logic [7:0] tx_all_ones,
    output logic [7:0] sys_ais_insert,
    output logic short_protect_disable,
    output logic ami_select,
    output logic attenuator_depth_select,
    output logic attenuator_bandwidth_select,
    output logic ja_in_tx,
    output logic ja_in_rx,
    output logic [23:0] tx_template,
    output logic [7:0] driver_highz,
    output logic irq
);
    liu_state_s s;
    liu_state_s next_s;
    logic [7:0] ais_edge;
    logic [7:0] los_edge;
    logic ais_read;

    always_comb begin
        next_s = s;
        // Detector levels cross in; a change counts once stages two and three agree
        next_s.los_s1 = los_in;
        next_s.los_s2 = s.los_s1;
        next_s.los_s3 = s.los_s2;
        next_s.ais_s1 = ais_in;
        next_s.ais_s2 = s.ais_s1;
        next_s.ais_s3 = s.ais_s2;
        for (int i = 0; i < 8; i++) begin
            if (s.los_s2[i] == s.los_s3[i]) begin
                next_s.los_stable[i] = s.los_s3[i];
            end
            if (s.ais_s2[i] == s.ais_s3[i]) begin
                next_s.ais_stable[i] = s.ais_s3[i];
            end
        end
        next_s.ais_prev = s.ais_stable;
        ais_read = rd && (addr == `LIU_OFS_AIS_STATUS);
        ais_edge = (s.ais_stable ^ s.ais_prev) & s.alarm_irq_mask;
        los_edge = (s.los_stable ^ next_s.los_stable);
        // Set wins over the read clear so an edge in the read cycle is kept
        next_s.alarm_irq_status = (ais_read ? 8'h00 : s.alarm_irq_status) | ais_edge;
        if (ais_read && (|s.alarm_irq_status)) begin
            next_s.irq_status[0] = 1'b1;
        end
        if (|los_edge) begin
            next_s.irq_status[1] = 1'b1;
        end
        if (wr) begin
            case (addr)
                `LIU_OFS_AUTO_ALL_ONES: next_s.auto_all_ones_enable = wdata;
                `LIU_OFS_GLOBAL_CONFIG: next_s.global_config = wdata & `LIU_CFG_WMASK;
                `LIU_OFS_TPL_POINTER: next_s.template_channel_pointer = wdata & `LIU_PTR_WMASK;
                `LIU_OFS_TPL_CODE: next_s.pulse_template_code[s.template_channel_pointer[2:0]] = wdata[2:0];
                `LIU_OFS_DRV_HIGHZ: next_s.driver_highz = wdata;
                `LIU_OFS_AIS_MASK: next_s.alarm_irq_mask = wdata;
                `LIU_OFS_IRQ_MASK: next_s.irq_mask = wdata[1:0];
                default: ;
            endcase
        end
        next_s.rdata = `LIU_REG_RESET;
        if (rd) begin
            case (addr)
                `LIU_OFS_LOS_STATUS: next_s.rdata = s.los_stable;
                `LIU_OFS_AUTO_ALL_ONES: next_s.rdata = s.auto_all_ones_enable;
                `LIU_OFS_GLOBAL_CONFIG: next_s.rdata = s.global_config;
                `LIU_OFS_TPL_POINTER: next_s.rdata = s.template_channel_pointer;
                `LIU_OFS_TPL_CODE: next_s.rdata = {5'h0_0, s.pulse_template_code[s.template_channel_pointer[2:0]]};
                `LIU_OFS_DRV_HIGHZ: next_s.rdata = s.driver_highz;
                `LIU_OFS_AIS_STATUS: next_s.rdata = s.ais_stable;
                `LIU_OFS_AIS_MASK: next_s.rdata = s.alarm_irq_mask;
                `LIU_OFS_AIS_IRQ: next_s.rdata = s.alarm_irq_status;
                `LIU_OFS_IRQ_STATUS: begin
                    next_s.rdata = {6'h0_0, s.irq_status};
                    next_s.irq_status = {|los_edge, ais_read && (|s.alarm_irq_status)};
                end
                `LIU_OFS_IRQ_MASK: next_s.rdata = {6'h0_0, s.irq_mask};
                default: next_s.rdata = `LIU_REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign tx_all_ones = s.auto_all_ones_enable & s.los_stable;
    assign sys_ais_insert = {8{s.global_config[`LIU_CFG_INSERT_BIT]}} & s.los_stable;
    assign short_protect_disable = s.global_config[`LIU_CFG_SHORT_BIT];
    assign ami_select = s.global_config[`LIU_CFG_CODE_BIT];
    assign attenuator_depth_select = s.global_config[`LIU_CFG_DEPTH_BIT];
    assign attenuator_bandwidth_select = s.global_config[`LIU_CFG_BW_BIT];
    assign ja_in_tx = (s.global_config[1:0] == `LIU_JA_TX);
    assign ja_in_rx = (s.global_config[1:0] == `LIU_JA_RX);
    assign tx_template = s.pulse_template_code;
    assign driver_highz = s.driver_highz;
    // Alarm line always reaches the pin; the second source is the loss-change flag, gated by its mask
    assign irq = (|s.alarm_irq_status) || (s.irq_status[1] && s.irq_mask[1]);

    sequence seq_alarm_edge(int ch);
        (s.ais_stable[ch] != s.ais_prev[ch]) && s.alarm_irq_mask[ch];
    endsequence

    AST_ALL_ONES: assert property (@(posedge clk) disable iff (!rst_n)
        tx_all_ones == (s.auto_all_ones_enable & s.los_stable)) else $error("all ones mismatch");
    AST_INSERT: assert property (@(posedge clk) disable iff (!rst_n)
        (s.global_config[`LIU_CFG_INSERT_BIT] == 1'b0) |-> (sys_ais_insert == 8'h00)) else $error("insert when off");
    AST_SHORT: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == `LIU_OFS_GLOBAL_CONFIG) |=> (short_protect_disable == $past(wdata[5]))) else $error("short bit");
    AST_CODE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == `LIU_OFS_GLOBAL_CONFIG) |=> (ami_select == $past(wdata[4]))) else $error("code bit");
    AST_JA: assert property (@(posedge clk) disable iff (!rst_n)
        !(ja_in_tx && ja_in_rx)) else $error("attenuator in both paths");
    AST_TPL_RW: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == `LIU_OFS_TPL_CODE) ##1 (rd && addr == `LIU_OFS_TPL_CODE)
        |=> (rdata[2:0] == $past(wdata[2:0], 2))) else $error("template readback");
    AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rd) |-> (rdata == 8'h00)) else $error("read data outside slot");
    AST_EDGE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        seq_alarm_edge(0) |=> s.alarm_irq_status[0]) else $error("edge not latched");
    AST_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
        (s.alarm_irq_mask == 8'h00 && !s.alarm_irq_status[0]) |=> !s.alarm_irq_status[0]) else $error("masked set");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && addr == `LIU_OFS_AIS_STATUS && ais_edge == 8'h00) |=> (s.alarm_irq_status == 8'h00)) else $error("no clear");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        (|s.alarm_irq_status) |-> irq) else $error("irq low with alarm pending");

    // Everything below shares one clock and one reset, so it leans on the defaults
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_write_to(logic [7:0] ofs);
        wr && (addr == ofs);
    endsequence

    sequence seq_read_of(logic [7:0] ofs);
        rd && (addr == ofs);
    endsequence

    sequence seq_ais_rise(int ch);
        !s.ais_prev[ch] && s.ais_stable[ch] && s.alarm_irq_mask[ch];
    endsequence

    sequence seq_ais_fall(int ch);
        s.ais_prev[ch] && !s.ais_stable[ch] && s.alarm_irq_mask[ch];
    endsequence

    AST_LOS_READ: assert property (
        seq_read_of(`LIU_OFS_LOS_STATUS)
        |=> (rdata == $past(s.los_stable)))
        else $error("loss status readback");

    AST_AIS_READ: assert property (
        seq_read_of(`LIU_OFS_AIS_STATUS)
        |=> (rdata == $past(s.ais_stable)))
        else $error("alarm status readback");

    AST_AIS_IRQ_READ: assert property (
        seq_read_of(`LIU_OFS_AIS_IRQ)
        |=> (rdata == $past(s.alarm_irq_status)))
        else $error("alarm interrupt readback");

    AST_TPL_READ: assert property (
        seq_read_of(`LIU_OFS_TPL_CODE)
        |=> (rdata == {5'h0_0, $past(s.pulse_template_code[s.template_channel_pointer[2:0]])}))
        else $error("template readback of pointed channel");

    AST_PTR_WRITE: assert property (
        seq_write_to(`LIU_OFS_TPL_POINTER)
        |=> (s.template_channel_pointer == ($past(wdata) & `LIU_PTR_WMASK)))
        else $error("pointer write");

    AST_PTR_RSVD: assert property (
        1'b1
        |-> (s.template_channel_pointer[7:3] == 5'h0_0))
        else $error("pointer reserved bits set");

    AST_GCF_WRITE: assert property (
        seq_write_to(`LIU_OFS_GLOBAL_CONFIG)
        |=> (s.global_config == ($past(wdata) & `LIU_CFG_WMASK)))
        else $error("global write");

    AST_DEPTH: assert property (
        seq_write_to(`LIU_OFS_GLOBAL_CONFIG)
        |=> (attenuator_depth_select == $past(wdata[3])))
        else $error("depth bit");

    AST_BW: assert property (
        seq_write_to(`LIU_OFS_GLOBAL_CONFIG)
        |=> (attenuator_bandwidth_select == $past(wdata[2])))
        else $error("bandwidth bit");

    AST_JA_TX: assert property (
        seq_write_to(`LIU_OFS_GLOBAL_CONFIG)
        |=> (ja_in_tx == ($past(wdata[1:0]) == `LIU_JA_TX)))
        else $error("attenuator transmit placement");

    AST_JA_RX: assert property (
        seq_write_to(`LIU_OFS_GLOBAL_CONFIG)
        |=> (ja_in_rx == ($past(wdata[1:0]) == `LIU_JA_RX)))
        else $error("attenuator receive placement");

    AST_INSERT_ON: assert property (
        s.global_config[`LIU_CFG_INSERT_BIT]
        |-> (sys_ais_insert == s.los_stable))
        else $error("insert missing during loss");

    AST_IRQ_QUIET: assert property (
        ((s.alarm_irq_status == 8'h00) && !(s.irq_status[1] && s.irq_mask[1]))
        |-> !irq)
        else $error("irq high with nothing pending");

    AST_READ_CLEAR: assert property (
        seq_read_of(`LIU_OFS_AIS_STATUS)
        |=> (s.alarm_irq_status == $past(ais_edge)))
        else $error("status read clear");

    AST_AUTO_READ: assert property (
        seq_read_of(`LIU_OFS_AUTO_ALL_ONES)
        |=> (rdata == $past(s.auto_all_ones_enable)))
        else $error("all ones enable readback");

    AST_DRV_READ: assert property (
        seq_read_of(`LIU_OFS_DRV_HIGHZ)
        |=> (rdata == $past(s.driver_highz)))
        else $error("driver control readback");

    AST_MASK_READ: assert property (
        seq_read_of(`LIU_OFS_AIS_MASK)
        |=> (rdata == $past(s.alarm_irq_mask)))
        else $error("alarm mask readback");

    // One copy per channel; channels share the bus, the global configuration, the template pointer and the irq pin
    for (genvar gi = 0; gi < 8; gi++) begin : g_chan
        AST_CH_ONES_ON: assert property (
            (s.auto_all_ones_enable[gi] && s.los_stable[gi])
            |-> tx_all_ones[gi])
            else $error("all ones missing");

        AST_CH_ONES_OFF: assert property (
            !s.auto_all_ones_enable[gi]
            |-> !tx_all_ones[gi])
            else $error("all ones while disabled");

        AST_CH_ONES_WRITE: assert property (
            seq_write_to(`LIU_OFS_AUTO_ALL_ONES)
            |=> (s.auto_all_ones_enable[gi] == $past(wdata[gi])))
            else $error("all ones enable write");

        AST_CH_INSERT_OFF: assert property (
            !s.los_stable[gi]
            |-> !sys_ais_insert[gi])
            else $error("insert without loss");

        AST_CH_LOS_HOLD: assert property (
            (s.los_s2[gi] != s.los_s3[gi])
            |=> (s.los_stable[gi] == $past(s.los_stable[gi])))
            else $error("loss filter moved on disagreement");

        AST_CH_LOS_TAKE: assert property (
            (s.los_s2[gi] == s.los_s3[gi])
            |=> (s.los_stable[gi] == $past(s.los_s3[gi])))
            else $error("loss filter missed agreement");

        AST_CH_AIS_HOLD: assert property (
            (s.ais_s2[gi] != s.ais_s3[gi])
            |=> (s.ais_stable[gi] == $past(s.ais_stable[gi])))
            else $error("alarm filter moved on disagreement");

        AST_CH_AIS_TAKE: assert property (
            (s.ais_s2[gi] == s.ais_s3[gi])
            |=> (s.ais_stable[gi] == $past(s.ais_s3[gi])))
            else $error("alarm filter missed agreement");

        AST_CH_RISE: assert property (
            seq_ais_rise(gi)
            |=> s.alarm_irq_status[gi])
            else $error("rising alarm not latched");

        AST_CH_FALL: assert property (
            seq_ais_fall(gi)
            |=> s.alarm_irq_status[gi])
            else $error("falling alarm not latched");

        AST_CH_BLOCKED: assert property (
            (!s.alarm_irq_mask[gi] && !s.alarm_irq_status[gi])
            |=> !s.alarm_irq_status[gi])
            else $error("blocked channel latched");

        AST_CH_STICKY: assert property (
            (s.alarm_irq_status[gi] && !(rd && (addr == `LIU_OFS_AIS_STATUS)))
            |=> s.alarm_irq_status[gi])
            else $error("alarm interrupt lost without read");

        AST_CH_QUIET: assert property (
            (!s.alarm_irq_status[gi] && (s.ais_stable[gi] == s.ais_prev[gi]))
            |=> !s.alarm_irq_status[gi])
            else $error("alarm interrupt without transition");

        AST_CH_HIGHZ: assert property (
            seq_write_to(`LIU_OFS_DRV_HIGHZ)
            |=> (driver_highz[gi] == $past(wdata[gi])))
            else $error("driver control write");

        AST_CH_HIGHZ_KEEP: assert property (
            !(wr && (addr == `LIU_OFS_DRV_HIGHZ))
            |=> $stable(driver_highz[gi]))
            else $error("driver control moved");

        AST_CH_TPL_SET: assert property (
            (wr && (addr == `LIU_OFS_TPL_CODE) && (s.template_channel_pointer[2:0] == 3'(gi)))
            |=> (tx_template[3*gi +: 3] == $past(wdata[2:0])))
            else $error("template write missed");

        AST_CH_TPL_KEEP: assert property (
            !(wr && (addr == `LIU_OFS_TPL_CODE) && (s.template_channel_pointer[2:0] == 3'(gi)))
            |=> $stable(tx_template[3*gi +: 3]))
            else $error("template of other channel moved");

        AST_CH_MASK_WRITE: assert property (
            seq_write_to(`LIU_OFS_AIS_MASK)
            |=> (s.alarm_irq_mask[gi] == $past(wdata[gi])))
            else $error("alarm mask write");

        AST_CH_IRQ: assert property (
            s.alarm_irq_status[gi]
            |-> irq)
            else $error("irq low with channel pending");
    end
endmodule
`default_nettype wire

// ==== tb/liu_line_model.sv ====
// Purpose: Line-side partner driving loss-of-signal and alarm levels
// Assumes: Levels change on the falling clock edge
// Notes: Detector levels are asynchronous to the bank, so they move off the sampling edge
`timescale 1ns/10ps
`default_nettype none
module liu_line_model (
    input wire logic clk,
    input wire logic [7:0] los_cmd,
    input wire logic [7:0] ais_cmd,
    output logic [7:0] los_in,
    output logic [7:0] ais_in
);
    always @(negedge clk) begin
        los_in <= los_cmd;
        ais_in <= ais_cmd;
    end
endmodule
`default_nettype wire

// ==== tb/liu_cfg_regs_tb.sv ====
// Purpose: Self-checking bench of the configuration and alarm bank
// Assumes: Detector inputs settle within a few cycles
// Notes: Fixed seed, random values with corner cases
`timescale 1ns/10ps
`default_nettype none
`include "liu_cfg_map.svh"
module liu_cfg_regs_tb
    import liu_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    liu_byte_t addr = 8'h00, wdata = 8'h00, los_cmd = 8'h00, ais_cmd = 8'h00;
    liu_byte_t rdata, los_in, ais_in, tx_all_ones, sys_ais_insert, driver_highz, v, m, r, ones;
    logic spd, ami, dep, bw, jt, jr, irq;
    logic [23:0] tx_template, tpl_exp;
    liu_tpl_t tpl [8];
    int errors = 0;
    int samples_checked = 0;
    liu_cfg_regs DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .los_in(los_in), .ais_in(ais_in), .tx_all_ones(tx_all_ones),
        .sys_ais_insert(sys_ais_insert), .short_protect_disable(spd), .ami_select(ami),
        .attenuator_depth_select(dep), .attenuator_bandwidth_select(bw), .ja_in_tx(jt),
        .ja_in_rx(jr), .tx_template(tx_template), .driver_highz(driver_highz), .irq(irq));
    liu_line_model line (.clk(clk), .los_cmd(los_cmd), .ais_cmd(ais_cmd), .los_in(los_in), .ais_in(ais_in));
    initial forever #20 clk = ~clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wreg(input liu_byte_t a, input liu_byte_t d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task rreg(input liu_byte_t a, output liu_byte_t d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task settle(input liu_byte_t l, input liu_byte_t s);
        los_cmd <= l;
        ais_cmd <= s;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task close_out;
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        v = 8'($urandom(65));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 14; a <= 23; a++) begin
            rreg(8'(a), v);
            chk(v, 0);
        end
        chk(irq, 0);
        ones = 8'($urandom);
        wreg(`LIU_OFS_AUTO_ALL_ONES, ones);
        rreg(`LIU_OFS_AUTO_ALL_ONES, v);
        chk(v, ones);
        m = 8'($urandom);
        wreg(`LIU_OFS_DRV_HIGHZ, m);
        chk(driver_highz, m);
        for (int k = 0; k < 2; k++) begin
            wreg(`LIU_OFS_GLOBAL_CONFIG, k ? 8'h40 : 8'h00);
            settle(8'($urandom), 8'h00);
            chk(tx_all_ones, ones & los_cmd);
            chk(sys_ais_insert, k ? los_cmd : 8'h00);
            rreg(`LIU_OFS_LOS_STATUS, v);
            chk(v, los_cmd);
        end
        for (int p = 0; p < 4; p++) begin
            v = 8'($urandom);
            v[1:0] = 2'(p);
            wreg(`LIU_OFS_GLOBAL_CONFIG, v);
            chk({spd, ami, dep, bw, jt, jr}, {v[5:2], v[1:0] == 2'b01, v[1:0] == 2'b11});
            rreg(`LIU_OFS_GLOBAL_CONFIG, m);
            chk(m, v & `LIU_CFG_WMASK);
        end
        for (int c = 0; c < 8; c++) begin
            tpl[c] = (c < 3) ? 3'(c) : 3'($urandom);
            wreg(`LIU_OFS_TPL_POINTER, 8'(c) | 8'hf8);
            wreg(`LIU_OFS_TPL_CODE, {5'h1f, tpl[c]});
        end
        for (int c = 7; c >= 0; c--) begin
            tpl_exp[3*c +: 3] = tpl[c];
            wreg(`LIU_OFS_TPL_POINTER, 8'(c));
            rreg(`LIU_OFS_TPL_CODE, v);
            chk(v, {5'h00, tpl[c]});
        end
        chk(tx_template, tpl_exp);
        wreg(8'h3c, 8'hff);
        rreg(8'h3c, v);
        chk(v, 0);
        m = 8'($urandom) | 8'h01;
        wreg(`LIU_OFS_AIS_MASK, m);
        v = 8'($urandom) | 8'h01;
        ais_cmd <= v;
        // Bounded wait; running out shows as a mismatch below
        for (int n = 0; n < 12 && irq !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk(irq, 1);
        settle(los_cmd, v);
        rreg(`LIU_OFS_AIS_IRQ, r);
        chk(r, m & v);
        rreg(`LIU_OFS_AIS_STATUS, r);
        chk(r, v);
        rreg(`LIU_OFS_AIS_IRQ, r);
        chk(r, 0);
        chk(irq, 0);
        settle(los_cmd, 8'h00);
        rreg(`LIU_OFS_AIS_IRQ, r);
        chk(r, m & v);
        rreg(`LIU_OFS_AIS_STATUS, r);
        chk(r, 0);
        wreg(`LIU_OFS_AIS_MASK, 8'h00);
        settle(los_cmd, 8'hff);
        rreg(`LIU_OFS_AIS_IRQ, r);
        chk(r, 0);
        chk(irq, 0);
        // Summary register: both sources pending, read clears them
        wreg(`LIU_OFS_IRQ_MASK, 8'h03);
        rreg(`LIU_OFS_IRQ_MASK, r);
        chk(r, 8'h03);
        settle(~los_cmd, 8'hff);
        chk(irq, 1);
        rreg(`LIU_OFS_IRQ_STATUS, r);
        chk(r, 8'h03);
        rreg(`LIU_OFS_IRQ_STATUS, r);
        chk(r, 0);
        chk(irq, 0);
        close_out();
    end
endmodule
`default_nettype wire
